/* hw/rbbs_exec.v */
// Purpose: executes relative branch and bit set in file instructions
// Assumes: instruction word valid from q1 of its cycle; data read returns same cycle
// Notes: other opcodes are treated as no operation
// Notes on behaviour
// RULE1: branch loads program counter with incremented value plus twice signed offset.
// RULE2: branch is one word and takes two instruction cycles.
// RULE3: first branch cycle decodes, reads offset, computes, writes program counter in q4.
// RULE4: bit set forces chosen bit to one, other bits kept.
// RULE5: bank flag zero selects quick-access bank, bank select ignored.
// RULE6: bank flag one takes bank from bank select register.
// RULE7: second branch cycle does nothing in every quarter phase.
`timescale 1ns/10ps
`include "rbbs_consts.vh"
module rbbs_exec (
  input wire ref_clk,
  input wire rstn,
  input wire [15:0] instr_word,
  input wire [3:0] bank_select_reg,
  input wire [7:0] data_rd,
  output reg [`RBBS_PC_W-1:0] program_counter_reg,
  output reg [`RBBS_DADDR_W-1:0] data_addr_reg,
  output reg [7:0] data_wr_reg,
  output reg data_we_reg,
  output reg [3:0] phase_out_reg,
  output reg busy_reg
);
  localparam ST_EXEC = 2'b01;
  localparam ST_NOP = 2'b10;
  wire [3:0] phase;
  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [`RBBS_PC_W-1:0] target_reg;
  reg [`RBBS_DADDR_W-1:0] addr_c;
  wire is_bra;
  wire is_bsf;
  wire exec_cyc;
  wire q1_en;
  wire q2_en;
  wire q3_en;
  wire q4_en;

  ////////////////////////////////////////////////////////////////
  rbbs_phase_gen u_phase (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .phase_reg(phase)
  );

  function [`RBBS_PC_W-1:0] rbbs_sext2;
    input [`RBBS_OFS_MSB:0] ofs;
    begin
      rbbs_sext2 = {{(`RBBS_PC_W-`RBBS_OFS_MSB-2){ofs[`RBBS_OFS_MSB]}}, ofs, 1'b0};
    end
  endfunction

  function [7:0] rbbs_set_bit;
    input [7:0] value;
    input [2:0] pos;
    begin
      rbbs_set_bit = value | (8'h01 << pos);
    end
  endfunction

  assign is_bra = (instr_word[15:11] == `RBBS_OP_BRA_HI);
  assign is_bsf = (instr_word[15:12] == `RBBS_OP_BSF_HI);

  ////////////////////////////////////////////////////////////////
  // quarter phase enables and executing-cycle flag
  assign exec_cyc = (state_reg == ST_EXEC);
  assign q1_en = phase[0];
  assign q2_en = phase[1];
  assign q3_en = phase[2];
  assign q4_en = phase[3];

  ////////////////////////////////////////////////////////////////
  always @*
  begin
    if (!instr_word[`RBBS_BANK_FLAG])
    begin
      if (instr_word[7:0] < `RBBS_ACC_SPLIT)
        addr_c = {4'h0, instr_word[7:0]}; // RULE5
      else
        addr_c = {`RBBS_ACC_HI_BANK, instr_word[7:0]}; // RULE5
    end
    else
      addr_c = {bank_select_reg, instr_word[7:0]}; // RULE6
  end

  always @*
  begin
    state_next = state_reg;
    case (state_reg)
      ST_EXEC:
      begin
        if (phase[3] && is_bra)
          state_next = ST_NOP; // RULE2
      end
      ST_NOP:
      begin
        if (phase[3])
          state_next = ST_EXEC; // RULE7
      end
      default:
        state_next = ST_EXEC;
    endcase
  end

  ////////////////////////////////////////////////////////////////
  // state register
  always @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      state_reg <= ST_EXEC;
    else
      state_reg <= state_next;
  end

  ////////////////////////////////////////////////////////////////
  // program counter: step at q1, branch target at q4
  always @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      program_counter_reg <= `RBBS_PC_RESET;
    else if (exec_cyc)
    begin
      if (q1_en)
        program_counter_reg <= program_counter_reg + `RBBS_PC_STEP;
      else if (q4_en && is_bra)
        program_counter_reg <= target_reg; // RULE3
    end
  end

  // branch target, latched in q3 from the stepped counter
  always @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      target_reg <= `RBBS_PC_RESET;
    else if (exec_cyc && q3_en && is_bra)
      target_reg <= program_counter_reg + rbbs_sext2(instr_word[`RBBS_OFS_MSB:0]); // RULE1
  end

  ////////////////////////////////////////////////////////////////
  // data address, latched in q2 of a bit set
  always @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      data_addr_reg <= `RBBS_DADDR_RESET;
    else if (exec_cyc && q2_en && is_bsf)
      data_addr_reg <= addr_c; // RULE5 RULE6
  end

  // write data and one-clock write strobe at q4
  always @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      data_wr_reg <= 8'h00;
      data_we_reg <= 1'b0;
    end
    else
    begin
      data_we_reg <= 1'b0; // RULE7
      if (exec_cyc && q4_en && is_bsf)
      begin
        data_wr_reg <= rbbs_set_bit(data_rd, instr_word[`RBBS_BIT_MSB:`RBBS_BIT_LSB]); // RULE4
        data_we_reg <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // phase copy and branch busy flag
  always @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      phase_out_reg <= 4'h0;
      busy_reg <= 1'b0;
    end
    else
    begin
      phase_out_reg <= phase;
      busy_reg <= (state_next == ST_NOP); // RULE2
    end
  end
endmodule

/* hw/rbbs_consts.vh */
// Purpose: constants for the relative branch and bit set execution block
// Assumes: 16-bit instruction words, 21-bit byte program counter, 12-bit data address
// Notes: quarter phases q1..q4 come from a divider on ref_clk
`ifndef RBBS_CONSTS_VH
`define RBBS_CONSTS_VH
`define RBBS_PC_W 21
`define RBBS_DADDR_W 12
`define RBBS_OP_BRA_HI 5'h1A
`define RBBS_OP_BSF_HI 4'h8
`define RBBS_OFS_MSB 10
`define RBBS_BIT_LSB 9
`define RBBS_BANK_FLAG 8
`define RBBS_ACC_SPLIT 8'h80
`define RBBS_ACC_HI_BANK 4'hF
`define RBBS_PC_RESET 21'h000000
`define RBBS_PC_STEP 21'h000002
`define RBBS_DADDR_RESET 12'h000
`define RBBS_BIT_MSB 11
`define RBBS_PHASE_COUNT 4
`endif

/* hw/rbbs_phase_gen.v */
// Purpose: quarter phase generator, one-hot q1..q4 enables
// Assumes: single ref_clk domain
// Notes: each phase lasts one ref_clk cycle
`timescale 1ns/10ps
`include "rbbs_consts.vh"
module rbbs_phase_gen (
  input wire ref_clk,
  input wire rstn,
  output reg [3:0] phase_reg
);
  always @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      phase_reg <= 4'h1;
    else
      phase_reg <= {phase_reg[2:0], phase_reg[3]};
  end
endmodule

/* sim/rbbs_exec_asserts.sv */
// Purpose: port checker for rbbs_exec
// Assumes: pc and busy land on the same q4 edge
// Notes: bound to every rbbs_exec
`timescale 1ns/10ps
module rbbs_exec_asserts (
  input wire ref_clk,
  input wire rstn,
  input wire [15:0] instr_word,
  input wire [3:0] bank_select_reg,
  input wire [7:0] data_rd,
  input wire [20:0] program_counter_reg,
  input wire [11:0] data_addr_reg,
  input wire [7:0] data_wr_reg,
  input wire data_we_reg,
  input wire [3:0] phase_out_reg,
  input wire busy_reg
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  property p_tgt; $rose(busy_reg) |-> program_counter_reg ==
    $past(program_counter_reg) + {{9{$past(instr_word[10])}}, $past(instr_word[10:0]), 1'b0}; endproperty
  a_tgt: assert property (p_tgt) else $error("branch target wrong");
  property p_len; $rose(busy_reg) |-> busy_reg [*4] ##1 !busy_reg; endproperty
  a_len: assert property (p_len) else $error("branch length wrong");
  property p_q4; $rose(busy_reg) |-> $changed(program_counter_reg); endproperty
  a_q4: assert property (p_q4) else $error("pc not written at q4");
  property p_set; data_we_reg |-> data_wr_reg == ($past(data_rd) | (8'h01 << $past(instr_word[11:9]))); endproperty
  a_set: assert property (p_set) else $error("bit set data wrong");
  property p_acc; data_we_reg && !$past(instr_word[8]) |->
    data_addr_reg == {($past(instr_word[7]) ? 4'hF : 4'h0), $past(instr_word[7:0])}; endproperty
  a_acc: assert property (p_acc) else $error("access bank address wrong");
  property p_bank; data_we_reg && $past(instr_word[8]) |->
    data_addr_reg == {$past(bank_select_reg), $past(instr_word[7:0])}; endproperty
  a_bank: assert property (p_bank) else $error("banked address wrong");
  property p_nop; busy_reg |-> !data_we_reg; endproperty
  a_nop: assert property (p_nop) else $error("write during no-op");
  property p_hold; busy_reg && $past(busy_reg) |-> $stable(program_counter_reg); endproperty
  a_hold: assert property (p_hold) else $error("pc moved during no-op");
  property p_phase; $past(phase_out_reg) != 4'h0 |->
    phase_out_reg == {$past(phase_out_reg[2:0]), $past(phase_out_reg[3])}; endproperty
  a_phase: assert property (p_phase) else $error("quarter phase order wrong");
endmodule
bind rbbs_exec rbbs_exec_asserts rbbs_exec_asserts_inst (.*);

/* sim/rel_branch_and_bit_set_exec_tb_top.sv */
// Purpose: directed bench for rbbs_exec
// Assumes: no-op cycle leaves pc alone
// Notes: data_rd is address xor 5A
`timescale 1ns/10ps
module rel_branch_and_bit_set_exec_tb_top;
  logic ref_clk = 0, rstn = 0, data_we_reg, busy_reg;
  logic [15:0] instr_word = 16'h0000;
  logic [3:0] bank_select_reg = 4'h3, phase_out_reg;
  logic [7:0] data_wr_reg;
  logic [20:0] program_counter_reg, pc_m = 21'h000000;
  logic [11:0] data_addr_reg;
  wire [7:0] data_rd = data_addr_reg[7:0] ^ 8'h5A;
  int num_errors = 0, n_tests = 0, cyc = 0;
  rbbs_exec rbbs_exec_inst (.*);
  initial forever #12.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (++cyc > 2000) begin num_errors++; conclude(); end
  task chk(string s, logic [20:0] e, logic [20:0] g);
    n_tests++;
    if (g !== e) begin num_errors++; $display("ERROR %s exp %h got %h", s, e, g); end
  endtask
  task run(logic [15:0] w);
    instr_word = w;
    repeat (4) @(posedge ref_clk);
    #1;
  endtask
  task t_branch(logic [10:0] n);
    pc_m = pc_m + 21'h000002 + {{9{n[10]}}, n, 1'b0};
    run({5'h1A, n});
    chk("pc", pc_m, program_counter_reg);
    chk("busy", 1, busy_reg);
    chk("phase q4", 4'h8, phase_out_reg);
    run(16'h8FFF);
    chk("busy end", 0, busy_reg);
    chk("we nop", 0, data_we_reg);
    chk("pc nop", pc_m, program_counter_reg);
    $display("branch %h done", n);
  endtask
  task t_bset(logic [2:0] b, logic a, logic [7:0] f);
    pc_m = pc_m + 21'h000002;
    run({4'h8, b, a, f});
    chk("we", 1, data_we_reg);
    chk("wr", (f ^ 8'h5A) | (8'h01 << b), data_wr_reg);
    chk("addr", {a ? bank_select_reg : (f[7] ? 4'hF : 4'h0), f}, data_addr_reg);
    chk("pc", pc_m, program_counter_reg);
    $display("bit set %h done", f);
  endtask
  task conclude;
    $display("tests %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge ref_clk);
    #1 rstn = 1;
    t_branch(11'h005);
    t_branch(11'h400);
    t_bset(3'h7, 0, 8'h0A);
    bank_select_reg = 4'h9;
    t_bset(3'h0, 0, 8'hC4);
    t_bset(3'h2, 1, 8'h21);
    t_branch(11'h7FF);
    conclude();
  end
endmodule
